// File: pll_ref_select_holdover_ctrl.sv
// Register block and pin logic for the PLL reference path:
// reference select, input power, holdover control, status, irq.
// Assumes APB master on ref_clk; pins synchronous to ref_clk.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module pll_ref_select_holdover_ctrl (
    // Clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           sys_rst,
    // APB slave
    input  wire logic [pll_ctrl_pkg::ADDR_W-1:0] paddr,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [pll_ctrl_pkg::DATA_W-1:0] pwdata,
    output var  logic [pll_ctrl_pkg::DATA_W-1:0] prdata,
    output logic                                pready,
    output logic                                pslverr,
    // Reference and lock inputs
    input  wire logic                           refSelectPin,
    input  wire logic                           selRefBad,
    input  wire logic                           lockPinCmp,
    input  wire logic                           lockFlagIn,
    input  wire logic                           holdReqPin,
    // Reference path controls
    output var  logic                           firstRefPowerOn,
    output var  logic                           secondRefPowerOn,
    output var  logic                           diffRefMode,
    output var  logic                           secondRefSelected,
    output logic                                holdoverActive,
    // Monitor pins and interrupt
    output var  logic                           refMonitorPin,
    output var  logic                           statusPin,
    output logic                                irq
);

    // ****************************************
    // Register storage
    // ****************************************
    logic [7:0]                     refCfgFf;
    logic [7:0]                     holdCtrlFf;
    logic [pll_ctrl_pkg::INT_W-1:0] intStatFf;
    logic [pll_ctrl_pkg::INT_W-1:0] intMaskFf;
    logic [pll_ctrl_pkg::DATA_W-1:0] prdataFf;

    logic                           holdPrevFf;
    logic                           lockPrevFf;
    logic                           cmpPrevFf;

    hold_if hif ();

    // ****************************************
    // Address decode
    // ****************************************
    logic [7:0] idx;
    logic       aligned;
    logic       hit;
    logic       wrEn;
    logic       rdSetup;
    logic       rdAccess;

    assign idx = paddr[pll_ctrl_pkg::IDX_HI:pll_ctrl_pkg::IDX_LO];
    assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    assign hit = aligned && (idx == pll_ctrl_pkg::REF_CFG_IDX
        || idx == pll_ctrl_pkg::HOLD_CTRL_IDX
        || idx == pll_ctrl_pkg::PLL_STAT_IDX
        || idx == pll_ctrl_pkg::INT_STAT_IDX
        || idx == pll_ctrl_pkg::INT_MASK_IDX);

    // Zero wait states: data is captured in the setup cycle
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !hit;
    assign wrEn     = psel && penable && pwrite && hit;
    assign rdSetup  = psel && !penable && !pwrite;
    assign rdAccess = psel && penable && !pwrite && hit;
    assign prdata   = prdataFf;

    // ****************************************
    // Control registers
    // ****************************************
    // reserved bits never stored
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            refCfgFf <= pll_ctrl_pkg::CFG_RESET;
        end else if (wrEn && idx == pll_ctrl_pkg::REF_CFG_IDX) begin
            refCfgFf <= pwdata[7:0] & pll_ctrl_pkg::CFG_WR_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            holdCtrlFf <= pll_ctrl_pkg::HC_RESET;
        end else if (wrEn && idx == pll_ctrl_pkg::HOLD_CTRL_IDX) begin
            holdCtrlFf <= pwdata[7:0] & pll_ctrl_pkg::HC_WR_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            intMaskFf <= pll_ctrl_pkg::INT_RESET;
        end else if (wrEn && idx == pll_ctrl_pkg::INT_MASK_IDX) begin
            intMaskFf <= pwdata[pll_ctrl_pkg::INT_W-1:0];
        end
    end

    // ****************************************
    // Reference selection and power
    // ****************************************
    logic useSecond;

    // no second input in differential mode
    always_comb begin
        if (refCfgFf[pll_ctrl_pkg::CFG_DIFF]) begin
            useSecond = 1'b0;
        end else if (refCfgFf[pll_ctrl_pkg::CFG_USE_PIN]) begin
            useSecond = refSelectPin;
        end else begin
            useSecond = refCfgFf[pll_ctrl_pkg::CFG_SEL_SECOND];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            firstRefPowerOn   <= 1'b0;
            secondRefPowerOn  <= 1'b0;
            diffRefMode       <= 1'b0;
            secondRefSelected <= 1'b0;
        end else begin
            firstRefPowerOn   <= refCfgFf[pll_ctrl_pkg::CFG_FIRST_PWR];
            secondRefPowerOn  <= refCfgFf[pll_ctrl_pkg::CFG_SECOND_PWR];
            diffRefMode       <= refCfgFf[pll_ctrl_pkg::CFG_DIFF];
            secondRefSelected <= useSecond;
        end
    end

    // ****************************************
    // Holdover controller hookup
    // ****************************************
    logic cmpEnable;
    logic cmpResult;
    logic cmpUsed;

    assign cmpEnable = holdCtrlFf[pll_ctrl_pkg::HC_CMP_EN];
    assign cmpResult = cmpEnable ? lockPinCmp : 1'b1;

    assign hif.holdEnable = holdCtrlFf[pll_ctrl_pkg::HC_EN_HI]
        && holdCtrlFf[pll_ctrl_pkg::HC_EN_LO];
    assign hif.extMode    = holdCtrlFf[pll_ctrl_pkg::HC_EXT];
    assign hif.cmpResult  = cmpResult;
    assign hif.holdReqPin = holdReqPin;
    assign hif.selRefBad  = selRefBad;
    assign holdoverActive = hif.holdActive;
    assign cmpUsed = hif.holdEnable && !hif.extMode && cmpEnable;

    // Software must clear the enables around VCO calibration; the
    // controller cannot see calibration, so it does not guard it
    holdover_fsm u_holdover (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .hif     (hif)
    );

    // comparator shown on pins when free
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            refMonitorPin <= 1'b1;
            statusPin     <= 1'b1;
        end else if (!cmpUsed) begin
            refMonitorPin <= !lockPinCmp;
            statusPin     <= !lockPinCmp;
        end else begin
            refMonitorPin <= !hif.holdActive;
            statusPin     <= !lockFlagIn;
        end
    end

    // ****************************************
    // Events and interrupt
    // ****************************************
    logic [pll_ctrl_pkg::INT_W-1:0] events;
    logic [pll_ctrl_pkg::INT_W-1:0] intClr;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            holdPrevFf <= 1'b0;
            lockPrevFf <= 1'b0;
            cmpPrevFf  <= 1'b0;
        end else begin
            holdPrevFf <= hif.holdActive;
            lockPrevFf <= lockFlagIn;
            cmpPrevFf  <= lockPinCmp;
        end
    end

    always_comb begin
        events = '0;
        events[pll_ctrl_pkg::INT_HOLD_IN]   = hif.holdActive && !holdPrevFf;
        events[pll_ctrl_pkg::INT_HOLD_OUT]  = !hif.holdActive && holdPrevFf;
        events[pll_ctrl_pkg::INT_LOCK_LOST] = !lockFlagIn && lockPrevFf;
        events[pll_ctrl_pkg::INT_CMP_CHG]   = lockPinCmp != cmpPrevFf;
    end

    // Only bits already shown to software are cleared
    assign intClr = (rdAccess && idx == pll_ctrl_pkg::INT_STAT_IDX)
        ? prdataFf[pll_ctrl_pkg::INT_W-1:0] : '0;

    // New events win over the read clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            intStatFf <= pll_ctrl_pkg::INT_RESET;
        end else begin
            intStatFf <= (intStatFf & ~intClr) | events;
        end
    end

    assign irq = |(intStatFf & intMaskFf);

    // ****************************************
    // Read data
    // ****************************************
    logic [7:0]                      pllStat;
    logic [pll_ctrl_pkg::DATA_W-1:0] rdMux;

    always_comb begin
        pllStat = 8'h00;
        pllStat[pll_ctrl_pkg::ST_HOLD]   = hif.holdActive;
        pllStat[pll_ctrl_pkg::ST_SECOND] = secondRefSelected;
        pllStat[pll_ctrl_pkg::ST_LOCK]   = lockFlagIn;
    end

    always_comb begin
        rdMux = '0;
        if (aligned) begin
            case (idx)
                pll_ctrl_pkg::REF_CFG_IDX:   rdMux[7:0] = refCfgFf;
                pll_ctrl_pkg::HOLD_CTRL_IDX: rdMux[7:0] = holdCtrlFf;
                pll_ctrl_pkg::PLL_STAT_IDX: begin
                    if (!holdCtrlFf[pll_ctrl_pkg::HC_STAT_DIS]) begin
                        rdMux[7:0] = pllStat;
                    end
                end
                pll_ctrl_pkg::INT_STAT_IDX:
                    rdMux[pll_ctrl_pkg::INT_W-1:0] = intStatFf;
                pll_ctrl_pkg::INT_MASK_IDX:
                    rdMux[pll_ctrl_pkg::INT_W-1:0] = intMaskFf;
                default: rdMux = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prdataFf <= '0;
        end else if (rdSetup) begin
            prdataFf <= rdMux;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_stat_read;
        rdSetup && aligned && idx == pll_ctrl_pkg::PLL_STAT_IDX;
    endsequence

    sequence s_cfg_write;
        wrEn && idx == pll_ctrl_pkg::REF_CFG_IDX;
    endsequence

    a_pin_select_path: assert property (
        !refCfgFf[pll_ctrl_pkg::CFG_DIFF]
        && refCfgFf[pll_ctrl_pkg::CFG_USE_PIN]
        |=> secondRefSelected == $past(refSelectPin))
        else $error("select pin not followed");

    a_reg_select_path: assert property (
        refCfgFf[pll_ctrl_pkg::CFG_USE_PIN] == 1'b0
        && !refCfgFf[pll_ctrl_pkg::CFG_DIFF]
        |=> secondRefSelected
            == $past(refCfgFf[pll_ctrl_pkg::CFG_SEL_SECOND]))
        else $error("register select not followed");

    a_power_after_write: assert property (
        s_cfg_write ##1 !wrEn
        |=> secondRefPowerOn
            == $past(pwdata[pll_ctrl_pkg::CFG_SECOND_PWR], 2)
            && firstRefPowerOn
            == $past(pwdata[pll_ctrl_pkg::CFG_FIRST_PWR], 2))
        else $error("input power does not follow config write");

    a_mode_after_write: assert property (
        s_cfg_write ##1 !wrEn
        |=> diffRefMode == $past(pwdata[pll_ctrl_pkg::CFG_DIFF], 2))
        else $error("reference mode does not follow write");

    a_diff_blocks_second: assert property (
        refCfgFf[pll_ctrl_pkg::CFG_DIFF] |=> !secondRefSelected)
        else $error("second input selected in differential mode");

    a_stat_blank: assert property (
        s_stat_read ##0 holdCtrlFf[pll_ctrl_pkg::HC_STAT_DIS]
        |=> prdata == '0)
        else $error("status readback not blanked");

    a_cmp_forced_true: assert property (
        !holdCtrlFf[pll_ctrl_pkg::HC_CMP_EN] |-> hif.cmpResult)
        else $error("disabled comparator not seen as true");

    a_cmp_on_pins: assert property (
        !cmpUsed |=> refMonitorPin == !$past(lockPinCmp)
            && statusPin == !$past(lockPinCmp))
        else $error("comparator not shown on monitor pins");

    a_hold_needs_both: assert property (
        !(holdCtrlFf[pll_ctrl_pkg::HC_EN_HI]
          && holdCtrlFf[pll_ctrl_pkg::HC_EN_LO]) |=> !holdoverActive)
        else $error("holdover active without both enables");

    a_stat_hold_lock: assert property (
        s_stat_read ##0 !holdCtrlFf[pll_ctrl_pkg::HC_STAT_DIS]
        |=> prdata[pll_ctrl_pkg::ST_HOLD] == $past(holdoverActive)
            && prdata[pll_ctrl_pkg::ST_LOCK] == $past(lockFlagIn))
        else $error("status bits do not show hold and lock");

    a_reserved_zero: assert property (
        s_cfg_write |=> refCfgFf[7] == 1'b0 && refCfgFf[4:3] == 2'h0)
        else $error("reserved bits stored");

endmodule : pll_ref_select_holdover_ctrl

`default_nettype wire

// File: pll_ctrl_pkg.sv
// Constants, register map and field layout of the PLL reference
// and holdover control block.
// Assumes a 32-bit APB master; addresses are byte addresses.
`default_nettype none

package pll_ctrl_pkg;

    // ****************************************
    // Bus geometry
    // ****************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_LO = 2;
    localparam int IDX_HI = 9;

    // Register indices; byte address is four times the index
    localparam logic [7:0] REF_CFG_IDX   = 8'h1C;
    localparam logic [7:0] HOLD_CTRL_IDX = 8'h1D;
    localparam logic [7:0] PLL_STAT_IDX  = 8'h1F;
    localparam logic [7:0] INT_STAT_IDX  = 8'h20;
    localparam logic [7:0] INT_MASK_IDX  = 8'h21;

    // ****************************************
    // Reference input configuration fields
    // ****************************************
    localparam int CFG_SEL_SECOND = 6;
    localparam int CFG_USE_PIN    = 5;
    localparam int CFG_SECOND_PWR = 2;
    localparam int CFG_FIRST_PWR  = 1;
    localparam int CFG_DIFF       = 0;
    localparam logic [7:0] CFG_WR_MASK = 8'h67;
    localparam logic [7:0] CFG_RESET   = 8'h00;

    // ****************************************
    // Holdover control fields
    // ****************************************
    localparam int HC_STAT_DIS = 4;
    localparam int HC_CMP_EN   = 3;
    localparam int HC_EN_HI    = 2;
    localparam int HC_EXT      = 1;
    localparam int HC_EN_LO    = 0;
    localparam logic [7:0] HC_WR_MASK = 8'h1F;
    localparam logic [7:0] HC_RESET   = 8'h00;

    // ****************************************
    // PLL status and interrupt fields
    // ****************************************
    localparam int ST_HOLD   = 5;
    localparam int ST_SECOND = 4;
    localparam int ST_LOCK   = 0;
    localparam int INT_W         = 4;
    localparam int INT_HOLD_IN   = 0;
    localparam int INT_HOLD_OUT  = 1;
    localparam int INT_LOCK_LOST = 2;
    localparam int INT_CMP_CHG   = 3;
    localparam logic [INT_W-1:0] INT_RESET = 4'h0;

endpackage : pll_ctrl_pkg

`default_nettype wire

// File: hold_if.sv
// Signals between the register block and the holdover controller.
// Assumes both ends share ref_clk.
`timescale 1ns/1ps
`default_nettype none

interface hold_if;
    logic holdEnable;
    logic extMode;
    logic cmpResult;
    logic holdReqPin;
    logic selRefBad;
    logic holdActive;

    modport ctrl (output holdEnable, extMode, cmpResult,
                  holdReqPin, selRefBad, input holdActive);
    modport fsm  (input holdEnable, extMode, cmpResult,
                  holdReqPin, selRefBad, output holdActive);
endinterface : hold_if

`default_nettype wire

// File: holdover_fsm.sv
// Holdover state machine: automatic or pin driven.
// Assumes all inputs synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none

module holdover_fsm (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Configuration and status
    hold_if.fsm      hif
);

    typedef enum logic {NORMAL, HOLDING} hold_state_t;

    hold_state_t stateFf;
    hold_state_t nxt_state;
    logic        holdActiveFf;

    always_comb begin
        nxt_state = stateFf;
        case (stateFf)
            NORMAL: begin
                if (hif.holdEnable && !hif.extMode && hif.selRefBad
                    && hif.cmpResult) begin
                    nxt_state = HOLDING;
                end
            end
            HOLDING: begin
                if (!hif.holdEnable || hif.extMode || !hif.selRefBad) begin
                    nxt_state = NORMAL;
                end
            end
            default: nxt_state = NORMAL;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stateFf <= NORMAL;
        end else begin
            stateFf <= nxt_state;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            holdActiveFf <= 1'b0;
        end else if (!hif.holdEnable) begin
            holdActiveFf <= 1'b0;
        end else if (hif.extMode) begin
            holdActiveFf <= hif.holdReqPin;
        end else begin
            holdActiveFf <= (nxt_state == HOLDING);
        end
    end

    assign hif.holdActive = holdActiveFf;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_auto_trigger;
        stateFf == NORMAL && hif.holdEnable && !hif.extMode
            && hif.selRefBad && hif.cmpResult;
    endsequence

    a_auto_hold_entry: assert property (@(posedge ref_clk)
        disable iff (sys_rst) s_auto_trigger ##1 hif.holdEnable
        |-> hif.holdActive)
        else $error("auto holdover not entered");

    a_ext_pin_follow: assert property (@(posedge ref_clk)
        disable iff (sys_rst) hif.holdEnable && hif.extMode
        |=> hif.holdActive == $past(hif.holdReqPin))
        else $error("external holdover pin not followed");

endmodule : holdover_fsm

`default_nettype wire

// File: ref_pin_model.sv
// Far-side model: reference sources and holdover, select pins.
// Assumes the bench sets pin levels right after a ref_clk edge.
`timescale 1ns/1ps
`default_nettype none

module ref_pin_model (
    // Pin levels commanded by the bench
    input  wire logic [4:0] cmd,
    // Pins towards the block
    output var  logic       refSelectPin,
    output var  logic       selRefBad,
    output var  logic       lockPinCmp,
    output var  logic       lockFlagIn,
    output var  logic       holdReqPin
);
    // Plain levels; these pins have no bus phases to model
    always_comb begin
        {refSelectPin, selRefBad, lockPinCmp, lockFlagIn, holdReqPin} = cmd;
    end
endmodule : ref_pin_model

`default_nettype wire

// File: pll_ref_select_holdover_ctrl_tb.sv
// Self-checking bench for the PLL reference and holdover block.
// Assumes zero-wait APB slave and pins sampled on ref_clk.
`timescale 1ns/1ps
`default_nettype none

module pll_ref_select_holdover_ctrl_tb;
    localparam logic [7:0] CFG = pll_ctrl_pkg::REF_CFG_IDX;
    localparam logic [7:0] HLD = pll_ctrl_pkg::HOLD_CTRL_IDX;
    localparam logic [7:0] STA = pll_ctrl_pkg::PLL_STAT_IDX;
    localparam logic [7:0] INS = pll_ctrl_pkg::INT_STAT_IDX;
    localparam logic [7:0] MSK = pll_ctrl_pkg::INT_MASK_IDX;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [11:0] paddr   = 12'h000;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [4:0]  cmd     = 5'h00;
    logic        rsp, bad, cmp, lck, hrq;
    logic        p1, p2, dif, sel, hld, mon, stp, irq;
    logic [31:0] rdat;
    logic        rerr;
    int          mismatches = 0;
    int          numChecks  = 0;

    always #20 ref_clk = ~ref_clk;

    pll_ref_select_holdover_ctrl u_pll_ref_select_holdover_ctrl (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .refSelectPin(rsp), .selRefBad(bad),
        .lockPinCmp(cmp), .lockFlagIn(lck), .holdReqPin(hrq),
        .firstRefPowerOn(p1), .secondRefPowerOn(p2),
        .diffRefMode(dif), .secondRefSelected(sel),
        .holdoverActive(hld), .refMonitorPin(mon), .statusPin(stp),
        .irq(irq)
    );

    ref_pin_model u_ref_pin_model (
        .cmd(cmd), .refSelectPin(rsp), .selRefBad(bad),
        .lockPinCmp(cmp), .lockFlagIn(lck), .holdReqPin(hrq)
    );

    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Setup then access; hold all until pready seen high
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        check(rdat, exp);
    endtask : rdc

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick

    task automatic t_reset();
        rdc(CFG, 32'h0000_0000);
        rdc(HLD, 32'h0000_0000);
        rdc(MSK, 32'h0000_0000);
        rdc(INS, 32'h0000_0000);
        check({p1, p2, dif, sel, hld}, 32'h0000_0000);
    endtask : t_reset

    task automatic t_cfg();
        wr(CFG, 32'h0000_00FF);
        rdc(CFG, 32'h0000_0067);
        tick(2);
        // Differential mode wins over the select bit
        check({p1, p2, dif, sel}, 32'h0000_000E);
        wr(CFG, 32'h0000_0040);
        tick(2);
        check({p1, p2, dif, sel}, 32'h0000_0001);
        rdc(STA, 32'h0000_0010);
        wr(CFG, 32'h0000_0020);
        cmd <= 5'h10;
        tick(3);
        check(sel, 32'h0000_0001);
        cmd <= 5'h00;
        tick(3);
        check(sel, 32'h0000_0000);
    endtask : t_cfg

    task automatic t_auto();
        wr(MSK, 32'h0000_000F);
        wr(HLD, 32'h0000_0001);
        cmd <= 5'h08;
        tick(3);
        check(hld, 32'h0000_0000);
        wr(HLD, 32'h0000_0005);
        tick(3);
        // Comparator off and its pin low still counts as true
        check({hld, irq}, 32'h0000_0003);
        rdc(STA, 32'h0000_0020);
        rdc(INS, 32'h0000_0001);
        // Clear lands on the access edge; look one edge later
        tick(1);
        check(irq, 32'h0000_0000);
        cmd <= 5'h00;
        tick(3);
        rdc(INS, 32'h0000_0002);
        wr(MSK, 32'h0000_0000);
        wr(HLD, 32'h0000_000D);
        cmd <= 5'h08;
        tick(3);
        check(hld, 32'h0000_0000);
        cmd <= 5'h0C;
        tick(3);
        check(hld, 32'h0000_0001);
        check({mon, stp, irq}, 32'h0000_0002);
        cmd <= 5'h00;
        tick(3);
        wr(MSK, 32'h0000_000F);
        tick(1);
        check(irq, 32'h0000_0001);
        rdc(INS, 32'h0000_000B);
    endtask : t_auto

    task automatic t_ext();
        wr(HLD, 32'h0000_0007);
        cmd <= 5'h01;
        tick(3);
        check(hld, 32'h0000_0001);
        cmd <= 5'h04;
        tick(3);
        check({hld, mon, stp}, 32'h0000_0000);
        cmd <= 5'h02;
        tick(3);
        check({mon, stp}, 32'h0000_0003);
        rdc(STA, 32'h0000_0001);
        wr(HLD, 32'h0000_0010);
        rdc(STA, 32'h0000_0000);
        // Auto holdover stays off from here on
        wr(HLD, 32'h0000_0000);
        apb(1'b0, 8'h1E, 32'h0000_0000);
        check(32'(rerr), 32'h0000_0001);
        check(rdat, 32'h0000_0000);
    endtask : t_ext

    initial begin
        repeat (200 * 20) @(posedge ref_clk);
        mismatches++;
        finish_test();
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_cfg();
        t_auto();
        t_ext();
        finish_test();
    end
endmodule : pll_ref_select_holdover_ctrl_tb

`default_nettype wire
